// *** adc_pm_consts.svh ***
// Constants for the converter power-mode control block
`ifndef ADC_PM_CONSTS_SVH
`define ADC_PM_CONSTS_SVH
// Register byte addresses
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_RESULT 12'h008
`define REG_IRQ_STATUS 12'h00C
`define REG_IRQ_MASK 12'h010
// Control byte fields
`define CTL_PD_HI 7
`define CTL_PD_LO 6
`define CTL_BIPOLAR 3
// Power-down / clock codes
`define PD_NORMAL_EXT 2'h0
`define PD_NORMAL_INT 2'h1
`define PD_STANDBY 2'h2
`define PD_FULL 2'h3
// Reset values
`define CONTROL_RESET 8'h00
`define MASK_RESET 2'h0
// Timing
`define CONV_TIME_NS 1200
`define CLOCK_NS 100
`define CONV_CYCLES ((`CONV_TIME_NS + `CLOCK_NS - 1) / `CLOCK_NS)
// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_SHUTDOWN 1
`endif

// *** adc_pm_pkg.sv ***
// Types for the converter power-mode control block
package adc_pm_pkg;
	typedef enum logic [1:0] {
		pm_normal,
		pm_standby,
		pm_full
	} power_mode_t;
	typedef struct packed {
		logic [1:0] trans;
		logic [11:0] addr;
		logic write;
	} ahb_req_t;
	typedef struct packed {
		logic bandgap_on;
		logic refbuf_on;
		logic internal_clock;
	} analog_ctl_t;
endpackage

// *** adc_power_mode_control.sv ***
// Power-mode, interrupt and result-coding control of the converter
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "adc_pm_consts.svh"
module adc_power_mode_control (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic shutdown_pin_n,
	input wire logic [11:0] sample_code,
	output logic conv_done_n,
	output logic converting,
	output logic bandgap_on,
	output logic refbuf_on,
	output logic internal_clock,
	output logic standby_powerdown,
	output logic full_powerdown,
	output logic irq
);
	// ---------------------------------------------
	// Bus address phase capture
	// ---------------------------------------------
	adc_pm_pkg::ahb_req_t req;
	logic req_valid;
	logic [7:0] control;
	logic [11:0] result;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [3:0] conv_count;
	logic clock_int_sel;
	logic shutdown_seen;
	adc_pm_pkg::power_mode_t mode;
	adc_pm_pkg::power_mode_t pending;
	logic wr_ctl;
	logic rd_result;
	logic conv_end;
	logic [11:0] coded;

	// Result coding: unipolar straight, bipolar offset flipped
	function automatic logic [11:0] code_result(input logic [11:0] raw,
		input logic bip);
		code_result = bip ? {~raw[11], raw[10:0]} : raw;
	endfunction

	// Address phase is latched when the bus is ready
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			req <= '0;
			req_valid <= 1'b0;
		end else if (hready) begin
			req.trans <= htrans;
			req.addr <= haddr[11:0];
			req.write <= hwrite;
			req_valid <= hsel && htrans[1];
		end else begin
			req_valid <= req_valid;
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Data-phase strobes; a low pin cancels a conversion end
	assign wr_ctl = req_valid && req.write && req.addr == `REG_CONTROL;
	assign rd_result = req_valid && !req.write && req.addr == `REG_RESULT;
	assign conv_end = converting && shutdown_pin_n && conv_count == 4'h1;
	assign coded = code_result(sample_code, control[`CTL_BIPOLAR]);

	// ---------------------------------------------
	// Control byte and clock mode
	// ---------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			control <= `CONTROL_RESET;
			clock_int_sel <= 1'b0;
		end else if (wr_ctl) begin
			control <= hwdata[7:0];
			// Power-down codes leave clock mode alone
			if (!hwdata[`CTL_PD_HI])
				clock_int_sel <= hwdata[`CTL_PD_LO];
		end
	end

	// ---------------------------------------------
	// Conversion timer, aborted by shutdown pin
	// ---------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			converting <= 1'b0;
			conv_count <= 4'h0;
		end else if (!shutdown_pin_n) begin
			converting <= 1'b0;
			conv_count <= 4'h0;
		end else if (wr_ctl) begin
			// A fresh write restarts the conversion
			converting <= 1'b1;
			conv_count <= 4'(`CONV_CYCLES);
		end else if (converting) begin
			conv_count <= conv_count - 4'h1;
			if (conv_count == 4'h1)
				converting <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Power mode state
	// ---------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode <= adc_pm_pkg::pm_normal;
			pending <= adc_pm_pkg::pm_normal;
			shutdown_seen <= 1'b0;
		end else if (!shutdown_pin_n) begin
			mode <= adc_pm_pkg::pm_full;
			pending <= adc_pm_pkg::pm_normal;
			shutdown_seen <= 1'b1;
		end else if (wr_ctl) begin
			mode <= adc_pm_pkg::pm_normal;
			shutdown_seen <= 1'b0;
			case (hwdata[`CTL_PD_HI:`CTL_PD_LO])
				`PD_STANDBY: pending <= adc_pm_pkg::pm_standby;
				`PD_FULL: pending <= adc_pm_pkg::pm_full;
				default: pending <= adc_pm_pkg::pm_normal;
			endcase
		end else if (conv_end) begin
			mode <= pending;
		end else if (shutdown_seen) begin
			mode <= adc_pm_pkg::pm_normal;
			shutdown_seen <= 1'b0;
		end
	end

	// Analog enables per mode; internal clock from the stored clock select, bandgap always on
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bandgap_on <= 1'b1;
			refbuf_on <= 1'b1;
			internal_clock <= 1'b0;
			standby_powerdown <= 1'b0;
			full_powerdown <= 1'b0;
		end else begin
			bandgap_on <= 1'b1;
			refbuf_on <= mode != adc_pm_pkg::pm_full;
			internal_clock <= clock_int_sel;
			standby_powerdown <= mode == adc_pm_pkg::pm_standby;
			full_powerdown <= mode == adc_pm_pkg::pm_full;
		end
	end

	// ---------------------------------------------
	// Result and conversion-done flag
	// ---------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			result <= 12'h000;
			conv_done_n <= 1'b1;
		end else if (conv_end && !wr_ctl) begin
			result <= coded;
			conv_done_n <= 1'b0;
		end else if (rd_result || wr_ctl) begin
			conv_done_n <= 1'b1;
		end
	end

	// ---------------------------------------------
	// Interrupt status and mask
	// ---------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_status <= 2'h0;
			irq_mask <= `MASK_RESET;
			irq <= 1'b0;
		end else begin
			// Set wins over write-one-to-clear
			irq_status <= (irq_status
				& ~((req_valid && req.write && req.addr == `REG_IRQ_STATUS)
				? hwdata[1:0] : 2'h0))
				| {!shutdown_pin_n, conv_end};
			if (req_valid && req.write && req.addr == `REG_IRQ_MASK)
				irq_mask <= hwdata[1:0];
			irq <= |(irq_status & irq_mask);
		end
	end

	// ---------------------------------------------
	// Read data, live in every power mode
	// ---------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (haddr[11:0] == `REG_CONTROL)
				hrdata <= {24'h000000, control};
			else if (haddr[11:0] == `REG_STATUS)
				hrdata <= {25'h0, shutdown_pin_n, conv_done_n,
					converting, internal_clock, refbuf_on, mode};
			else if (haddr[11:0] == `REG_RESULT)
				hrdata <= {20'h00000, result};
			else if (haddr[11:0] == `REG_IRQ_STATUS)
				hrdata <= {30'h0, irq_status};
			else if (haddr[11:0] == `REG_IRQ_MASK)
				hrdata <= {30'h0, irq_mask};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	// Control write with the shutdown pin released
	sequence write_seq;
		wr_ctl && shutdown_pin_n;
	endsequence

	// Pin low, then released with no write behind it
	sequence release_seq;
		!shutdown_pin_n ##1 (shutdown_pin_n && !wr_ctl);
	endsequence

	// Reset leaves done high, normal mode, external clock
	AST_RESET_STATE: assert property (@(posedge clock)
		!rst_n |=> conv_done_n && !internal_clock && !converting &&
		mode == adc_pm_pkg::pm_normal)
		else $error("reset state wrong");
	AST_WAIT_CONV: assert property (@(posedge clock)
		disable iff (!rst_n)
		converting |-> mode == adc_pm_pkg::pm_normal)
		else $error("power-down during conversion");
	AST_FULL_AT_END: assert property (@(posedge clock)
		disable iff (!rst_n)
		conv_end && !wr_ctl && pending == adc_pm_pkg::pm_full
		|=> mode == adc_pm_pkg::pm_full)
		else $error("full power-down not taken at end");
	AST_BUS_LIVE: assert property (@(posedge clock)
		disable iff (!rst_n)
		hready && hsel && htrans[1] && !hwrite &&
		haddr[11:0] == `REG_RESULT |=> hrdata[11:0] == $past(result))
		else $error("result not readable");
	AST_WRITE_WAKES: assert property (@(posedge clock)
		disable iff (!rst_n)
		write_seq |=> mode == adc_pm_pkg::pm_normal && converting)
		else $error("write did not wake");
	AST_PIN_DOWN: assert property (@(posedge clock)
		disable iff (!rst_n)
		!shutdown_pin_n |=> mode == adc_pm_pkg::pm_full && !converting)
		else $error("shutdown not immediate");
	AST_ABORT_KEEP: assert property (@(posedge clock)
		disable iff (!rst_n)
		!shutdown_pin_n |=> $stable(result))
		else $error("aborted conversion stored a result");
	AST_PIN_EVENT: assert property (@(posedge clock)
		disable iff (!rst_n)
		!shutdown_pin_n |=> irq_status[`IRQ_SHUTDOWN])
		else $error("shutdown event not flagged");
	AST_STBY_BUF: assert property (@(posedge clock)
		disable iff (!rst_n)
		mode == adc_pm_pkg::pm_standby |=> refbuf_on && bandgap_on)
		else $error("buffer off in standby");
	AST_FULL_BUF: assert property (@(posedge clock)
		disable iff (!rst_n)
		mode == adc_pm_pkg::pm_full |=> !refbuf_on && bandgap_on)
		else $error("buffer on in full power-down");
	AST_AUTO_STBY: assert property (@(posedge clock)
		disable iff (!rst_n)
		conv_end && !wr_ctl && pending == adc_pm_pkg::pm_standby
		|=> mode == adc_pm_pkg::pm_standby)
		else $error("standby not taken at end");
	AST_CONV_LEN: assert property (@(posedge clock)
		disable iff (!rst_n)
		write_seq ##1 (shutdown_pin_n && !wr_ctl) [*8] |-> converting)
		else $error("conversion ended early");
	AST_CODING: assert property (@(posedge clock)
		disable iff (!rst_n)
		conv_end && !wr_ctl |=> result == $past(coded))
		else $error("result coding wrong");
	AST_CLOCK_KEPT: assert property (@(posedge clock)
		disable iff (!rst_n)
		wr_ctl && hwdata[`CTL_PD_HI] |=> $stable(clock_int_sel))
		else $error("power-down code changed clock mode");
	AST_DONE_SET: assert property (@(posedge clock)
		disable iff (!rst_n)
		conv_end && !wr_ctl |=> !conv_done_n)
		else $error("done flag not set");
	AST_DONE_CLR: assert property (@(posedge clock)
		disable iff (!rst_n)
		rd_result && !conv_end |=> conv_done_n)
		else $error("done flag not cleared");
	AST_DONE_EVENT: assert property (@(posedge clock)
		disable iff (!rst_n)
		conv_end |=> irq_status[`IRQ_DONE])
		else $error("done event not flagged");
	AST_RELEASE_IDLE: assert property (@(posedge clock)
		disable iff (!rst_n)
		release_seq |=> !converting && mode == adc_pm_pkg::pm_normal)
		else $error("not idle after pin release");
endmodule // adc_power_mode_control

// *** host_bus_model.sv ***
// Host model: single-word AHB-Lite master
`timescale 1ns/1ns
module host_bus_model (
	input wire logic clock,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One word, each phase held until hready
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		r = hrdata;
	endtask
endmodule // host_bus_model

// *** tb_adc_power_mode_control.sv ***
// Testbench for the converter power-mode control
`timescale 1ns/1ns
`include "adc_pm_consts.svh"
module tb_adc_power_mode_control;
	logic clock, rst_n, shutdown_pin_n, hsel, hwrite, ic;
	logic hreadyout, hresp, conv_done_n, converting, irq;
	logic bandgap_on, refbuf_on, internal_clock;
	logic standby_powerdown, full_powerdown;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [11:0] sample_code;
	int failures, n_tests;

	host_bus_model i_host (.clock(clock), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	adc_power_mode_control i_dut (.clock(clock), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .shutdown_pin_n(shutdown_pin_n),
		.sample_code(sample_code), .conv_done_n(conv_done_n),
		.converting(converting), .bandgap_on(bandgap_on),
		.refbuf_on(refbuf_on), .internal_clock(internal_clock),
		.standby_powerdown(standby_powerdown),
		.full_powerdown(full_powerdown), .irq(irq));

	// Compare and count
	task automatic chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Expected result coding
	function automatic logic [11:0] coded(input logic [11:0] c,
		input logic b);
		return b ? {~c[11], c[10:0]} : c;
	endfunction

	// One conversion with a power-down code
	task automatic conv(input logic [1:0] pd, input logic b);
		int n;
		logic [11:0] c;
		c = 12'($urandom);
		sample_code <= c;
		i_host.xfer(`REG_CONTROL, 1'b1, {24'h0, pd, 2'h0, b, 3'h0}, r);
		// Mode outputs follow the mode one cycle later
		@(posedge clock);
		#1;
		chk(converting, 1'b1);
		chk(standby_powerdown | full_powerdown, 1'b0);
		n = 0;
		while (converting !== 1'b0 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
		#1;
		if (pd < 2'h2) ic = pd[0];
		chk(conv_done_n, 1'b0);
		chk(internal_clock, ic);
		chk(standby_powerdown, pd == 2'h2);
		chk(full_powerdown, pd == 2'h3);
		chk(refbuf_on, pd != 2'h3);
		chk(bandgap_on, 1'b1);
		i_host.xfer(`REG_RESULT, 1'b0, 32'h0, r);
		chk(r[11:0], coded(c, b));
		#1;
		chk(conv_done_n, 1'b1);
		$display("test conversion code %0d done", pd);
	endtask

	// Final counts and verdict
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Watchdog
	initial begin
		#2000000;
		failures++;
		complete_run();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		shutdown_pin_n = 1'b1;
		sample_code = 12'h000;
		ic = 1'b0;
		failures = 0;
		n_tests = 0;
		void'($urandom(32'hE89C5D85));
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk(conv_done_n, 1'b1);
		chk(internal_clock, 1'b0);
		chk(standby_powerdown | full_powerdown, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) conv(2'(i), 1'($urandom));
		conv(2'h2, 1'b1);
		// Interrupt raise, clear and mask
		i_host.xfer(`REG_IRQ_MASK, 1'b1, 32'h3, r);
		conv(2'h0, 1'b0);
		repeat (2) @(posedge clock);
		#1;
		chk(irq, 1'b1);
		i_host.xfer(`REG_IRQ_STATUS, 1'b1, 32'h3, r);
		repeat (2) @(posedge clock);
		#1;
		chk(irq, 1'b0);
		i_host.xfer(`REG_IRQ_MASK, 1'b1, 32'h0, r);
		conv(2'h1, 1'b0);
		chk(irq, 1'b0);
		i_host.xfer(12'h020, 1'b0, 32'h0, r);
		chk(r, 32'h0);
		$display("test interrupt done");
		// Shutdown pin in mid-conversion
		i_host.xfer(`REG_CONTROL, 1'b1, 32'h0, r);
		@(posedge clock);
		shutdown_pin_n <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk(full_powerdown, 1'b1);
		chk(converting, 1'b0);
		chk(refbuf_on, 1'b0);
		i_host.xfer(`REG_STATUS, 1'b0, 32'h0, r);
		chk(r[6:0], 7'h22);
		i_host.xfer(`REG_IRQ_STATUS, 1'b0, 32'h0, r);
		chk(r, 32'h3);
		shutdown_pin_n <= 1'b1;
		repeat (20) @(posedge clock);
		#1;
		chk(converting, 1'b0);
		chk(conv_done_n, 1'b1);
		chk(full_powerdown, 1'b0);
		$display("test shutdown done");
		complete_run();
	end
endmodule // tb_adc_power_mode_control
